// File: global_shared_regs_pkg.sv
/*
 * constants, field layout and reset values of the shared register group
 * that both the local processor bus and vme masters reach.
 * assumes one 250 mhz clock and requesters that hold their strobe until
 * the matching acknowledge.
 */
package global_shared_regs_pkg;
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   localparam logic [31:0] LB_BASE = 32'hfff40100;
   localparam int LB_SPAN_LSB = 5;
   localparam logic [5:0] AM_SHORT_USR = 6'h29;
   localparam logic [5:0] AM_SHORT_SUP = 6'h2d;
   localparam logic [3:0] BOARD_LM = 4'hf;
   // ---------------------------------------------------------------
   // register indices and fields
   // ---------------------------------------------------------------
   localparam logic [2:0] REG_ID = 3'h0;
   localparam logic [2:0] REG_LMSIG = 3'h1;
   localparam logic [2:0] REG_GP0 = 3'h2;
   localparam int NUM_GP = 6;
   localparam int LM_LSB = 12;
   localparam int SIG_LSB = 8;
   localparam int BC_RST = 7;
   localparam int BC_ISF = 6;
   localparam int BC_BF = 5;
   localparam int BC_SCON = 4;
   localparam int BC_SYSFL = 3;
   localparam logic [3:0] LM_RESET = 4'hf;
   localparam logic [3:0] SIG_RESET = 4'h0;
   localparam logic [15:0] GP_RESET = 16'h0000;
   // ---------------------------------------------------------------
   // identity (values arbitrary) and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] CHIP_ID_DEF = 8'h5a;
   localparam logic [7:0] CHIP_REV_DEF = 8'h03;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int LRST_TIME_NS = 1000;
   localparam int LRST_CYCLES =
      (LRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LRST_W = 9;
   typedef enum logic [1:0] {LK_NONE, LK_LB, LK_VME} lock_t;
endpackage : global_shared_regs_pkg

// File: global_shared_regs.sv
/*
 * global_shared_regs: the shared register group with location monitors,
 * remote doorbells, board control and six mailbox words.
 * assumes synchronous request strobes held until acknowledged, and a
 * local interrupter and reset tree outside that consume the outputs.
 */
`timescale 1ns/1ps
module global_shared_regs
   import global_shared_regs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // local processor bus
   input wire logic lb_req_i,
   input wire logic lb_we_i,
   input wire logic lb_rmw_i,
   input wire logic [31:0] lb_addr_i,
   input wire logic [1:0] lb_be_i,
   input wire logic [15:0] lb_wdata_i,
   output logic lb_ack_o,
   output logic [15:0] lb_rdata_o,
   // vme slave side
   input wire logic vme_req_i,
   input wire logic vme_we_i,
   input wire logic vme_rmw_i,
   input wire logic vme_own_i,
   input wire logic [5:0] vme_am_i,
   input wire logic [15:0] vme_addr_i,
   input wire logic [1:0] vme_be_i,
   input wire logic [15:0] vme_wdata_i,
   output logic vme_ack_o,
   output logic [15:0] vme_rdata_o,
   // selects and local interrupt clear register
   input wire logic [7:0] group_sel_i,
   input wire logic [3:0] board_sel_i,
   input wire logic [3:0] lic_clr_sig_i,
   input wire logic [1:0] lic_set_lm_i,
   // board status
   input wire logic sysfail_want_i,
   input wire logic sys_ctrl_i,
   input wire logic sysfail_line_i,
   // outputs to interrupter and board
   output logic [1:0] lm_irq_o,
   output logic [3:0] sig_irq_o,
   output logic [3:0] lm_status_o,
   output logic local_reset_o,
   output logic sysfail_inhibit_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] lm;
      logic [3:0] sig;
      logic isf;
      logic [LRST_W-1:0] rst_cnt;
      logic [NUM_GP-1:0][15:0] gp;
      lock_t lock;
      logic lb_seen;
      logic vme_seen;
      logic lb_ack;
      logic vme_ack;
      logic [15:0] lb_rdata;
      logic [15:0] vme_rdata;
      logic [1:0] lm_pulse;
   } state_t;

   localparam state_t STATE_RESET = '{
      lm: LM_RESET, sig: SIG_RESET, isf: 1'b0, rst_cnt: '0,
      gp: {NUM_GP{GP_RESET}}, lock: LK_NONE, lb_seen: 1'b0,
      vme_seen: 1'b0, lb_ack: 1'b0, vme_ack: 1'b0, lb_rdata: '0,
      vme_rdata: '0, lm_pulse: '0};

   state_t s_r;
   state_t s_nxt;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic lb_hit;
   logic am_ok;
   logic vme_grp;
   logic vme_reg_hit;
   logic vme_lm_hit;
   logic [1:0] lm_idx;
   logic lrst_active;
   logic take_lb;
   logic take_vme;
   logic sel_we;
   logic sel_vme;
   logic [2:0] sel_idx;
   logic [1:0] sel_be;
   logic [15:0] sel_wd;
   logic [15:0] rd_word;
   logic [2:0] gp_idx;

   // local decoder sits on the 32-byte window at the base
   assign lb_hit = (lb_addr_i[31:LB_SPAN_LSB] ==
                    LB_BASE[31:LB_SPAN_LSB]);
   assign am_ok = (vme_am_i == AM_SHORT_USR) ||
                  (vme_am_i == AM_SHORT_SUP);
   assign vme_grp = am_ok && (vme_addr_i[15:8] == group_sel_i);
   // board value f is never a board: it carries the monitors
   assign vme_reg_hit = vme_grp && (board_sel_i != BOARD_LM) &&
                        (vme_addr_i[7:4] == board_sel_i);
   // odd low nibble 1,3,5,7 picks monitor 0..3, either direction
   assign vme_lm_hit = vme_grp && (vme_addr_i[7:4] == BOARD_LM) &&
                       vme_addr_i[0] && !vme_addr_i[3];
   assign lm_idx = vme_addr_i[2:1];
   assign lrst_active = (s_r.rst_cnt != '0);

   // local wins a tie; a held rmw lock keeps the other side out
   assign take_lb = lb_req_i && lb_hit && !s_r.lb_seen && !lrst_active &&
                    (s_r.lock != LK_VME);
   assign take_vme = vme_req_i && (vme_reg_hit || vme_lm_hit) &&
                     !s_r.vme_seen && (s_r.lock != LK_LB) &&
                     !take_lb;

   assign sel_vme = !take_lb;
   assign sel_we = take_lb ? lb_we_i : vme_we_i;
   assign sel_idx = take_lb ? lb_addr_i[4:2] : vme_addr_i[3:1];
   assign sel_be = take_lb ? lb_be_i : vme_be_i;
   assign sel_wd = take_lb ? lb_wdata_i : vme_wdata_i;
   assign gp_idx = sel_idx - REG_GP0;

   // read word before any write of the same access (rmw read half)
   always_comb begin
      case (sel_idx)
         REG_ID: rd_word = {CHIP_REV_DEF, CHIP_ID_DEF};
         REG_LMSIG: begin
            rd_word = '0;
            rd_word[LM_LSB+:4] = s_r.lm;
            rd_word[SIG_LSB+:4] = s_r.sig;
            rd_word[BC_RST] = lrst_active;
            rd_word[BC_ISF] = s_r.isf;
            rd_word[BC_BF] = sysfail_want_i;
            rd_word[BC_SCON] = sys_ctrl_i;
            rd_word[BC_SYSFL] = sysfail_line_i;
         end
         default: rd_word = s_r.gp[gp_idx];
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.lb_ack = 1'b0;
      s_nxt.vme_ack = 1'b0;
      s_nxt.lm_pulse = '0;
      if (!lb_req_i) s_nxt.lb_seen = 1'b0;
      if (!vme_req_i) s_nxt.vme_seen = 1'b0;
      if (lrst_active) s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
      // clears first so a same-cycle set below wins
      s_nxt.sig = s_nxt.sig & ~lic_clr_sig_i;
      s_nxt.lm[1:0] = s_nxt.lm[1:0] | lic_set_lm_i;
      // release lock when its owner drops the rmw marker
      if ((s_r.lock == LK_LB) && (!lb_rmw_i || lrst_active))
         s_nxt.lock = LK_NONE;
      if ((s_r.lock == LK_VME) && !vme_rmw_i)
         s_nxt.lock = LK_NONE;
      if (take_lb) begin
         s_nxt.lb_seen = 1'b1;
         s_nxt.lb_ack = 1'b1;
         s_nxt.lb_rdata = rd_word;
         if (lb_rmw_i) s_nxt.lock = LK_LB;
      end
      if (take_vme) begin
         s_nxt.vme_seen = 1'b1;
         if (vme_rmw_i) s_nxt.lock = LK_VME;
      end
      if (take_vme && vme_lm_hit) begin
         // the whole group sees this cycle; ours clears too
         s_nxt.lm[lm_idx] = 1'b0;
         if (!lm_idx[1]) s_nxt.lm_pulse[lm_idx[0]] = 1'b1;
         s_nxt.vme_ack = vme_own_i;
         s_nxt.vme_rdata = '0;
      end
      if (take_vme && !vme_lm_hit) begin
         s_nxt.vme_ack = 1'b1;
         s_nxt.vme_rdata = rd_word;
      end
      if ((take_lb || (take_vme && !vme_lm_hit)) && sel_we) begin
         case (sel_idx)
            REG_ID: s_nxt.lock = s_nxt.lock; // read only
            REG_LMSIG: begin
               if (sel_be[1]) begin
                  s_nxt.lm = s_nxt.lm | sel_wd[LM_LSB+:4];
                  if (sel_vme)
                     s_nxt.sig = s_nxt.sig |
                                 sel_wd[SIG_LSB+:4];
                  else
                     s_nxt.sig = s_nxt.sig &
                                 ~sel_wd[SIG_LSB+:4];
               end
               if (sel_be[0]) begin
                  s_nxt.isf = sel_wd[BC_ISF];
                  if (sel_wd[BC_RST] && sel_vme)
                     s_nxt.rst_cnt = LRST_W'(LRST_CYCLES);
               end
            end
            default: begin
               // byte lanes merge independently
               if (sel_be[1])
                  s_nxt.gp[gp_idx][15:8] = sel_wd[15:8];
               if (sel_be[0])
                  s_nxt.gp[gp_idx][7:0] = sel_wd[7:0];
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         s_r <= STATE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign lb_ack_o = s_r.lb_ack;
   assign lb_rdata_o = s_r.lb_rdata;
   assign vme_ack_o = s_r.vme_ack;
   assign vme_rdata_o = s_r.vme_rdata;
   assign lm_irq_o = s_r.lm_pulse;
   assign sig_irq_o = s_r.sig;
   assign lm_status_o = s_r.lm;
   assign local_reset_o = lrst_active;
   assign sysfail_inhibit_o = s_r.isf;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence seq_lm0_cycle;
      take_vme && vme_lm_hit && (lm_idx == 2'd0);
   endsequence
   sequence seq_vme_sig_write;
      take_vme && !vme_lm_hit && vme_we_i && vme_be_i[1] &&
      (vme_addr_i[3:1] == REG_LMSIG);
   endsequence
   sequence seq_reset_req;
      seq_vme_sig_write ##0 vme_be_i[0] && vme_wdata_i[BC_RST];
   endsequence

   a_lb_ack_local: assert property (
      take_lb |=> lb_ack_o && (lb_rdata_o == $past(rd_word)))
      else $error("local access not acknowledged next cycle");
   a_lm_clear_irq: assert property (
      seq_lm0_cycle ##0 !lic_set_lm_i[0] |=> lm_irq_o[0] && !lm_status_o[0])
      else $error("monitor 0 cycle did not clear and interrupt");
   a_lm_foreign_noack: assert property (
      take_vme && vme_lm_hit && !vme_own_i |=> !vme_ack_o)
      else $error("foreign monitor cycle acknowledged");
   a_am_filter: assert property (
      vme_ack_o |-> $past(am_ok))
      else $error("vme acknowledge without short i/o modifier");
   a_sig_set: assert property (
      seq_vme_sig_write |=> (sig_irq_o & $past(vme_wdata_i[SIG_LSB+:4]))
                            == $past(vme_wdata_i[SIG_LSB+:4]))
      else $error("doorbell not set by vme write");
   a_sig_clear: assert property (
      lic_clr_sig_i[0] && !take_vme |=> !sig_irq_o[0])
      else $error("doorbell not cleared by clear register");
   a_lock_serial: assert property (
      (s_r.lock == LK_VME) |-> !take_lb ##0 !(take_lb && take_vme))
      else $error("local access during vme read-modify-write");
   a_rst_pulse: assert property (
      seq_reset_req |=> local_reset_o [*8])
      else $error("remote local reset too short");
endmodule : global_shared_regs

// File: vme_master_model.sv
/* far-side vme master that runs one transfer per call of xfer.
   assumes the caller drives nothing else on the vme request lines. */
`timescale 1ns/1ps
module vme_master_model
   import global_shared_regs_pkg::*;
(
   // clock and answer
   input wire logic ref_clk_i,
   input wire logic ack_i,
   input wire logic [15:0] rdata_i,
   input wire logic [1:0] irq_i,
   // request
   output logic req_o,
   output logic we_o,
   output logic rmw_o,
   output logic own_o,
   output logic [5:0] am_o,
   output logic [15:0] addr_o,
   output logic [1:0] be_o,
   output logic [15:0] wdata_o
);
   initial begin
      {req_o, we_o, rmw_o, own_o, be_o} = 6'h0;
      am_o = 6'h0;
      addr_o = 16'h0;
      wdata_o = 16'h0;
   end
   // ---------------------------------------------------------------
   // one transfer, held until acknowledged or the bound runs out
   // ---------------------------------------------------------------
   task automatic xfer(logic we, rmw, own, logic [5:0] am, logic [15:0] a,
      logic [1:0] be, logic [15:0] wd, int lim, output logic [15:0] rd,
      output logic k, output logic [1:0] irq);
      @(negedge ref_clk_i);
      we_o = we;
      rmw_o = rmw;
      own_o = own;
      am_o = am;
      addr_o = a;
      be_o = be;
      wdata_o = wd;
      req_o = 1'h1;
      k = 1'h0;
      irq = 2'h0;
      for (int i = 0; i < lim && !k; i++) begin
         @(negedge ref_clk_i);
         k = (ack_i === 1'h1);
         irq = irq | irq_i;
      end
      rd = rdata_i;
      req_o = 1'h0;
      // released address and data lines do not keep their last value
      addr_o = ~a;
      wdata_o = ~wd;
      if (we) rmw_o = 1'h0;
   endtask : xfer
endmodule : vme_master_model

// File: global_shared_regs_tb.sv
/* self-checking bench: local side driven here, vme side by the master
   model. assumes the package constants and one 250 mhz clock. */
`timescale 1ns/1ps
module global_shared_regs_tb;
   import global_shared_regs_pkg::*;
   logic ref_clk_i = 1'h0, nrst_i = 1'h0, lb_req_i = 1'h0, lb_we_i = 1'h0;
   logic lb_rmw_i = 1'h0, sysfail_want_i, sys_ctrl_i, sysfail_line_i;
   logic [31:0] lb_addr_i = 32'h0;
   logic [1:0] lb_be_i = 2'h0, lic_set_lm_i = 2'h0, vme_be_i, lm_irq_o, irq;
   logic [15:0] lb_wdata_i = 16'h0, lb_rdata_o, vme_rdata_o, rd, vrd, d;
   logic [7:0] group_sel_i = 8'h3c;
   logic [3:0] board_sel_i = 4'h5, lic_clr_sig_i = 4'h0;
   logic [3:0] sig_irq_o, lm_status_o;
   logic [5:0] vme_am_i, am = AM_SHORT_USR;
   logic [15:0] vme_addr_i, vme_wdata_i;
   logic vme_req_i, vme_we_i, vme_rmw_i, vme_own_i, lb_ack_o, vme_ack_o;
   logic local_reset_o, sysfail_inhibit_o, lk, vk;
   int error_cnt = 0, comparisons = 0, lm = 15, sig = 0, n = 0;
   int mb[6];
   global_shared_regs i_global_shared_regs (
      .ref_clk_i, .nrst_i, .lb_req_i, .lb_we_i, .lb_rmw_i, .lb_addr_i,
      .lb_be_i, .lb_wdata_i, .lb_ack_o, .lb_rdata_o, .vme_req_i, .vme_we_i,
      .vme_rmw_i, .vme_own_i, .vme_am_i, .vme_addr_i, .vme_be_i,
      .vme_wdata_i, .vme_ack_o, .vme_rdata_o, .group_sel_i, .board_sel_i,
      .lic_clr_sig_i, .lic_set_lm_i, .sysfail_want_i, .sys_ctrl_i,
      .sysfail_line_i, .lm_irq_o, .sig_irq_o, .lm_status_o, .local_reset_o,
      .sysfail_inhibit_o);
   vme_master_model i_vme_master_model (
      .ref_clk_i, .ack_i(vme_ack_o), .rdata_i(vme_rdata_o), .irq_i(lm_irq_o),
      .req_o(vme_req_i), .we_o(vme_we_i), .rmw_o(vme_rmw_i),
      .own_o(vme_own_i), .am_o(vme_am_i), .addr_o(vme_addr_i),
      .be_o(vme_be_i), .wdata_o(vme_wdata_i));
   initial forever #2 ref_clk_i = ~ref_clk_i;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic need(logic k);
      chk("ack", 16'(k), 16'h1);
      if (k !== 1'h1) wrap_up();
   endtask : need
   function automatic logic [15:0] va(int ix);
      return {group_sel_i, board_sel_i, 3'(ix), 1'h0};
   endfunction : va
   function automatic logic [15:0] ma(int i, logic [7:0] g);
      return {g, 8'(8'hf1 + 2 * i)};
   endfunction : ma
   task automatic lbx(logic we, logic [31:0] a, logic [1:0] be,
      logic [15:0] wd, int lim);
      @(negedge ref_clk_i);
      {lb_we_i, lb_addr_i, lb_be_i, lb_wdata_i} = {we, a, be, wd};
      lb_req_i = 1'h1;
      lk = 1'h0;
      for (int i = 0; i < lim && !lk; i++) begin
         @(negedge ref_clk_i);
         lk = (lb_ack_o === 1'h1);
      end
      rd = lb_rdata_o;
      lb_req_i = 1'h0;
      {lb_addr_i, lb_wdata_i} = {~a, ~wd};
   endtask : lbx
   task automatic vx(logic we, rmw, own, logic [15:0] a, logic [1:0] be,
      logic [15:0] wd, int lim);
      i_vme_master_model.xfer(we, rmw, own, am, a, be, wd, lim, vrd, vk, irq);
   endtask : vx
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h17a66d2d));
      {sysfail_want_i, sys_ctrl_i, sysfail_line_i} = 3'($urandom);
      repeat (12) @(negedge ref_clk_i);
      nrst_i = 1'h1;
      chk("lm", 16'(lm_status_o), 16'h000f);
      lbx(1'h0, LB_BASE, 2'h3, 16'h0, 20);
      need(lk);
      chk("id", rd, {CHIP_REV_DEF, CHIP_ID_DEF});
      for (int i = 0; i < NUM_GP; i++) begin
         mb[i] = int'($urandom);
         lbx(1'h1, LB_BASE + 32'(4 * i + 8), 2'h3, mb[i][15:0], 20);
      end
      lbx(1'h1, LB_BASE + 32'h10, 2'h2, 16'h12ff, 20);
      mb[2][15:8] = 8'h12;
      vx(1'h1, 1'h0, 1'h0, va(3), 2'h1, 16'hffa5, 20);
      mb[1][7:0] = 8'ha5;
      for (int i = 0; i < NUM_GP; i++) begin
         am = i[0] ? AM_SHORT_SUP : AM_SHORT_USR;
         vx(1'h0, 1'h0, 1'h0, va(i + 2), 2'h3, 16'h0, 20);
         chk("mailbox", vrd, mb[i][15:0]);
      end
      am = 6'h39;
      vx(1'h0, 1'h0, 1'h0, va(2), 2'h3, 16'h0, 8);
      chk("am_refused", 16'(vk), 16'h0);
      am = AM_SHORT_USR;
      vx(1'h0, 1'h0, 1'h0, va(2) ^ 16'h0100, 2'h3, 16'h0, 8);
      chk("group_refused", 16'(vk), 16'h0);
      lbx(1'h0, LB_BASE - 32'h4, 2'h3, 16'h0, 8);
      chk("lb_refused", 16'(lk), 16'h0);
      for (int i = 0; i < 4; i++) begin
         vx(i[0], 1'h0, 1'h1, ma(i, group_sel_i), 2'h1, 16'h0, 20);
         need(vk);
         lm = lm & ~(1 << i);
         chk("lm", 16'(lm_status_o), 16'(lm));
         chk("lm_irq", 16'(irq), 16'(i < 2 ? 1 << i : 0));
      end
      lbx(1'h1, LB_BASE + 32'h4, 2'h2, 16'hf000, 20);
      chk("lm", 16'(lm_status_o), 16'h000f);
      for (int i = 0; i < 2; i++) begin
         vx(1'h0, 1'h0, 1'h0, ma(i, group_sel_i), 2'h1, 16'h0, 6);
         chk("lm_ack", 16'(vk), 16'h0);
      end
      vx(1'h0, 1'h0, 1'h1, ma(2, ~group_sel_i), 2'h1, 16'h0, 6);
      chk("lm_ack", 16'(vk), 16'h0);
      chk("lm", 16'(lm_status_o), 16'h000c);
      @(negedge ref_clk_i) lic_set_lm_i = 2'h3;
      @(negedge ref_clk_i) lic_set_lm_i = 2'h0;
      @(negedge ref_clk_i);
      chk("lm", 16'(lm_status_o), 16'h000f);
      d = 16'($urandom_range(15, 1)) << 8;
      vx(1'h1, 1'h0, 1'h0, va(1), 2'h2, d, 20);
      sig = int'(d[11:8]);
      @(negedge ref_clk_i);
      chk("sig", 16'(sig_irq_o), 16'(sig));
      lbx(1'h1, LB_BASE + 32'h4, 2'h2, 16'h0500, 20);
      sig = sig & 10;
      chk("sig", 16'(sig_irq_o), 16'(sig));
      @(negedge ref_clk_i) lic_clr_sig_i = 4'ha;
      @(negedge ref_clk_i) lic_clr_sig_i = 4'h0;
      @(negedge ref_clk_i);
      chk("sig", 16'(sig_irq_o), 16'h0);
      vx(1'h1, 1'h0, 1'h0, va(1), 2'h1, 16'h0040, 20);
      chk("inhibit", 16'(sysfail_inhibit_o), 16'h1);
      vx(1'h0, 1'h0, 1'h0, va(1), 2'h3, 16'h0, 20);
      chk("board", vrd, {10'h3c1, sysfail_want_i, sys_ctrl_i,
         sysfail_line_i, 3'h0});
      // remote reset used once, as a last resort
      fork
         vx(1'h1, 1'h0, 1'h0, va(1), 2'h1, 16'h0080, 20);
         begin
            repeat (4) @(negedge ref_clk_i);
            lbx(1'h0, LB_BASE, 2'h3, 16'h0, 20);
         end
         for (int i = 0; i < 600; i++) begin
            @(negedge ref_clk_i);
            n += int'(local_reset_o === 1'h1);
         end
      join
      chk("lb_in_reset", 16'(lk), 16'h0);
      chk("reset_len", 16'(n), 16'(LRST_CYCLES));
      chk("inhibit", 16'(sysfail_inhibit_o), 16'h0);
      fork
         begin
            vx(1'h0, 1'h1, 1'h0, va(5), 2'h3, 16'h0, 20);
            d = vrd;
            vx(1'h1, 1'h1, 1'h0, va(5), 2'h3, vrd | 16'h8000, 20);
         end
         begin
            @(negedge ref_clk_i);
            lbx(1'h1, LB_BASE + 32'h14, 2'h3, 16'h1234, 40);
         end
      join
      chk("tas_old", d, mb[3][15:0]);
      need(lk);
      lbx(1'h0, LB_BASE + 32'h14, 2'h3, 16'h0, 20);
      chk("tas_order", rd, 16'h1234);
      wrap_up();
   end
endmodule : global_shared_regs_tb
